// ==== rtl/auf_uart.sv ====
// uart core: framing, rate generator, autobaud measurement and axi4-lite registers
// Contract
// - five formats: 7, 8, even, odd, address
// - transmit line idles at mark
// - start, data, optional ninth, stop bits
// - start is space, stop is mark
// - bit lasts one baud from 16-bit divisor
// - data bits go lsb first
// - tx and rx independent, shared format
// - hardware makes and checks parity
// - shifter loads only from holding register
// - autobaud only in 8-bit and lin
// - dali mode ignores arm bit
// - first falling edge starts, receiver held idle
// - fifth fall stores count, clears arm, flags
// - quiet low first fall, high fifth rise
// - divisor keeps old value until done
// - measurement at one eighth base rate
// - wake with arm skips the break
// - invert changes tx pin at once
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
module auf_uart (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_line,
  output logic             tx_line
);
  logic [10:0] ctrl_q;
  logic [15:0] div_q;
  logic [8:0]  hold_q;
  logic        hold_full_q;
  logic [8:0]  rxd_q;
  logic        rx_full_q, perr_q, ferr_q, done_flag_q;
  logic        aw_q, w_q;
  logic [7:0]  awa_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        bvalid_q, rvalid_q, awready_q, wready_q, arready_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        tx_q;
  logic [6:0]  pre_q;
  logic [15:0] rdiv_q;
  logic [2:0]  oct_q;
  logic [15:0] meas_q;
  logic [2:0]  falls_q, rises_q;
  logic        meas_q_on, quiet_q, rx_d1_q, skip_q;
  logic        brk_seen_q;

  // control decode
  wire auf_pkg::auf_mode_t mode = auf_pkg::auf_mode_t'(ctrl_q[auf_pkg::CTL_MODE_LSB +: 3]);
  wire logic arm      = ctrl_q[auf_pkg::CTL_ARM];
  wire logic txen     = ctrl_q[auf_pkg::CTL_TXEN];
  wire logic rxen     = ctrl_q[auf_pkg::CTL_RXEN];
  wire logic prescale = ctrl_q[auf_pkg::CTL_PRESCALE];
  wire logic wake     = ctrl_q[auf_pkg::CTL_WAKE];
  wire logic invert   = ctrl_q[auf_pkg::CTL_INVERT];
  wire logic stop2    = ctrl_q[auf_pkg::CTL_STOP2];
  wire logic ninth    = (mode == auf_pkg::AUF_MODE_EVEN) || (mode == auf_pkg::AUF_MODE_ODD) ||
                        (mode == auf_pkg::AUF_MODE_ADDR);
  wire logic seven    = mode == auf_pkg::AUF_MODE_7BIT;
  // lin runs autobaud on its own; dali and parity modes never do
  wire logic abd_mode = (mode == auf_pkg::AUF_MODE_8BIT && arm) ||
                        (mode == auf_pkg::AUF_MODE_LIN);
  // data+ninth+stop count (start excluded); second stop only on tx
  wire logic [3:0] nb_rx = (seven ? 4'h7 : 4'h8) + {3'h0, ninth} + 4'h1;
  wire logic [3:0] nb_tx = nb_rx + {3'h0, stop2};
  wire logic [7:0] dbyte = seven ? {1'b0, hold_q[6:0]} : hold_q[7:0];
  wire logic par_t = ^dbyte ^ (mode == auf_pkg::AUF_MODE_ODD);
  wire logic nine_v = !ninth ? 1'b1 : (mode == auf_pkg::AUF_MODE_ADDR) ? hold_q[8] : par_t;
  wire logic [8:0] tx_load = seven ? {2'b11, hold_q[6:0]} : {nine_v, dbyte}; // stop fills slot

  // rate generator: prescale then 16x oversample tick from divisor
  wire logic [6:0] pre_lim = prescale ? auf_pkg::PRE_FAST : auf_pkg::PRE_SLOW;
  wire logic base_tick = pre_q == pre_lim;
  wire logic os_tick   = base_tick && rdiv_q == div_q;
  wire logic abd_tick  = base_tick && oct_q == 3'(auf_pkg::ABD_RATIO - 1);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_q  <= 7'h00;
      rdiv_q <= 16'h0000;
      oct_q  <= 3'h0;
    end
    else if (clk_en)
    begin
      pre_q  <= base_tick ? 7'h00 : pre_q + 7'h01;
      if (base_tick)
      begin
        rdiv_q <= (rdiv_q == div_q) ? 16'h0000 : rdiv_q + 16'h0001;
        oct_q  <= oct_q + 3'h1;
      end
    end
  end

  // autobaud: edges of rx time the measurement counter
  wire logic fall = rx_d1_q && !rx_line;
  wire logic rise = !rx_d1_q && rx_line;
  wire logic abd_end = meas_q_on && fall && falls_q == 3'h4;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_d1_q   <= 1'b1;
      meas_q_on <= 1'b0;
      meas_q    <= 16'h0000;
      falls_q   <= 3'h0;
      rises_q   <= 3'h0;
      quiet_q   <= 1'b1;
      skip_q    <= 1'b0;
      brk_seen_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_d1_q <= rx_line;
      if (!abd_mode)
      begin
        meas_q_on  <= 1'b0;
        skip_q     <= 1'b0;
        brk_seen_q <= 1'b0;
      end
      else if (!meas_q_on && fall && wake && !skip_q && !brk_seen_q)
        skip_q <= 1'b1; // break falls, wait for its end
      else if (skip_q && rise)
      begin
        skip_q     <= 1'b0;
        brk_seen_q <= 1'b1; // only one break is skipped, the sync is timed
      end
      else if (!meas_q_on && fall && !skip_q)
      begin
        meas_q_on <= 1'b1;
        meas_q    <= 16'h0000;
        falls_q   <= 3'h1;
        rises_q   <= 3'h0;
        quiet_q   <= 1'b0;
      end
      else if (meas_q_on)
      begin
        if (abd_tick)
          meas_q <= meas_q + 16'h0001;
        if (fall)
          falls_q <= falls_q + 3'h1;
        if (abd_end)
        begin
          meas_q_on  <= 1'b0;
          brk_seen_q <= 1'b0;
        end
      end
      if (!quiet_q && rise)
      begin
        rises_q <= rises_q + 3'h1;
        if (rises_q == 3'h4)
          quiet_q <= 1'b1;
      end
    end
  end

  // transmit and receive engines share format and rate only
  logic       tx_busy, tx_done, rx_busy, rx_done, tx_raw;
  logic [9:0] rx_frame;
  wire logic tx_go = txen && hold_full_q && !tx_busy;
  wire logic rx_go = rxen && !abd_mode && fall && !rx_busy;
  auf_shifter u_tx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (clk_en),
    .tick      (os_tick),
    .is_tx     (1'b1),
    .start     (tx_go),
    .nbits     (nb_tx),
    .load_data (tx_load),
    .line_in   (1'b1),
    .busy      (tx_busy),
    .line_out  (tx_raw),
    .frame_q   (),
    .done      (tx_done)
  );
  auf_shifter u_rx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (clk_en),
    .tick      (os_tick),
    .is_tx     (1'b0),
    .start     (rx_go),
    .nbits     (nb_rx),
    .load_data (9'h1ff),
    .line_in   (rx_line),
    .busy      (rx_busy),
    .line_out  (),
    .frame_q   (rx_frame),
    .done      (rx_done)
  );
  // received frame right-aligned; data at top end sits below stop bit
  wire logic [9:0] rx_al   = rx_frame >> (4'd10 - nb_rx);
  wire logic [8:0] rx_data = seven ? {2'b00, rx_al[6:0]} : rx_al[8:0];
  wire logic rx_stop = seven ? rx_al[7] : (ninth ? rx_al[9] : rx_al[8]);
  wire logic rx_perr = ((mode == auf_pkg::AUF_MODE_EVEN) || (mode == auf_pkg::AUF_MODE_ODD)) &&
                       ((^rx_al[8:0]) != (mode == auf_pkg::AUF_MODE_ODD));

  // axi write and read channel decode
  wire logic wr_go = aw_q && w_q && !bvalid_q;
  wire logic wr_hi = ws_q[1];
  wire logic wr_lo = ws_q[0];
  wire logic wr_ctrl = wr_go && awa_q == auf_pkg::OFS_CTRL;
  wire logic wr_stat = wr_go && awa_q == auf_pkg::OFS_STATUS;
  wire logic wr_div  = wr_go && awa_q == auf_pkg::OFS_DIV;
  wire logic wr_hold = wr_go && awa_q == auf_pkg::OFS_TXHOLD;
  wire logic wr_ok   = wr_ctrl || wr_stat || wr_div || wr_hold;
  wire logic rd_go   = s_axi_arvalid && arready_q;
  wire logic rd_rx   = rd_go && s_axi_araddr == auf_pkg::OFS_RXDATA;
  wire logic [31:0] stat_word = {25'h0, rxd_q[8] && mode == auf_pkg::AUF_MODE_ADDR, ferr_q,
                                 perr_q, rx_full_q, !hold_full_q, quiet_q, done_flag_q};
  wire logic [31:0] rd_word =
    (s_axi_araddr == auf_pkg::OFS_CTRL)   ? {21'h0, ctrl_q} :
    (s_axi_araddr == auf_pkg::OFS_STATUS) ? stat_word :
    (s_axi_araddr == auf_pkg::OFS_DIV)    ? {16'h0, div_q} :
    (s_axi_araddr == auf_pkg::OFS_RXDATA) ? {23'h0, rxd_q} : 32'h0; // holding reg reads 0
  wire logic rd_ok = s_axi_araddr == auf_pkg::OFS_CTRL || s_axi_araddr == auf_pkg::OFS_STATUS ||
                     s_axi_araddr == auf_pkg::OFS_DIV || s_axi_araddr == auf_pkg::OFS_RXDATA ||
                     s_axi_araddr == auf_pkg::OFS_TXHOLD;

  // axi handshake: capture address and data in either order, then respond
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h0; ws_q <= 4'h0;
      awready_q <= 1'b1; wready_q <= 1'b1; arready_q <= 1'b1;
      bvalid_q <= 1'b0; rvalid_q <= 1'b0; bresp_q <= 2'b00; rresp_q <= 2'b00;
      rdata_q <= 32'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && awready_q)
      begin
        aw_q <= 1'b1; awa_q <= s_axi_awaddr; awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        w_q <= 1'b1; wd_q <= s_axi_wdata; ws_q <= s_axi_wstrb; wready_q <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? auf_pkg::RESP_OKAY : auf_pkg::RESP_SLVERR;
        aw_q <= 1'b0; w_q <= 1'b0;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0; awready_q <= 1'b1; wready_q <= 1'b1;
      end
      if (rd_go)
      begin
        rvalid_q <= 1'b1; arready_q <= 1'b0; rdata_q <= rd_word;
        rresp_q <= rd_ok ? auf_pkg::RESP_OKAY : auf_pkg::RESP_SLVERR;
      end
      if (rvalid_q && s_axi_rready)
      begin
        rvalid_q <= 1'b0; arready_q <= 1'b1;
      end
    end
  end

  // software registers; hardware sets beat software clears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= auf_pkg::CTRL_RESET; div_q <= auf_pkg::DIV_RESET;
      hold_q <= 9'h000; hold_full_q <= 1'b0; rxd_q <= 9'h000;
      rx_full_q <= 1'b0; perr_q <= 1'b0; ferr_q <= 1'b0; done_flag_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_ctrl && wr_lo)
        ctrl_q[7:0] <= wd_q[7:0];
      if (wr_ctrl && wr_hi)
        ctrl_q[10:8] <= wd_q[10:8];
      if (wr_div && wr_lo)
        div_q[7:0] <= wd_q[7:0]; // low divisor byte
      if (wr_div && wr_hi)
        div_q[15:8] <= wd_q[15:8]; // high divisor byte
      if (abd_end)
      begin
        div_q <= meas_q;
        ctrl_q[auf_pkg::CTL_ARM] <= 1'b0;
      end
      if (wr_stat && wr_lo && wd_q[auf_pkg::ST_DONE])
        done_flag_q <= 1'b0;
      if (abd_end)
        done_flag_q <= 1'b1;
      if (tx_go)
        hold_full_q <= 1'b0;
      if (wr_hold && wr_lo)
      begin
        hold_q <= wd_q[8:0]; hold_full_q <= 1'b1;
      end
      if (rd_rx)
        rx_full_q <= 1'b0;
      if (rx_done)
      begin
        rxd_q <= rx_data; rx_full_q <= 1'b1;
        perr_q <= rx_perr; ferr_q <= !rx_stop;
      end
    end
  end

  // pin register; polarity applies regardless of txen, on every clk_en cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_q <= 1'b1;
    else if (clk_en)
      tx_q <= (txen ? tx_raw : 1'b1) ^ invert;
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign tx_line       = tx_q;

  chk_idle_mark: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !tx_busy && !invert |=> tx_line) else $error("tx not at mark when idle");
  chk_arm_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && abd_end |=> !arm && done_flag_q) else $error("autobaud end not flagged");
  chk_div_load: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && abd_end |=> div_q == $past(meas_q)) else $error("divisor not loaded");
  chk_div_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_q_on && !abd_end && !wr_div |=> $stable(div_q)) else $error("divisor moved");
  chk_rx_held: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && abd_mode && !rx_busy |=> !rx_busy) else $error("receiver started during autobaud");
  chk_invert_now: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && $changed(invert) && !$changed(tx_raw) && !$changed(txen) |=> $changed(tx_line))
    else $error("invert did not flip pin");
  chk_dali_arm: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == auf_pkg::AUF_MODE_DALI |-> !abd_mode) else $error("dali autobaud");
  chk_done_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    done_flag_q && !wr_stat |=> done_flag_q) else $error("done flag lost");
endmodule

// ==== rtl/auf_pkg.sv ====
// package: register map, field positions, modes and timing constants for the uart core
package auf_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIV    = 8'h08;
  localparam logic [7:0] OFS_TXHOLD = 8'h0c;
  localparam logic [7:0] OFS_RXDATA = 8'h10;
  // control field positions
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_TXEN     = 4;
  localparam int CTL_RXEN     = 5;
  localparam int CTL_ARM      = 6;
  localparam int CTL_PRESCALE = 7;
  localparam int CTL_WAKE     = 8;
  localparam int CTL_INVERT   = 9;
  localparam int CTL_STOP2    = 10;
  // status field positions
  localparam int ST_DONE   = 0;
  localparam int ST_QUIET  = 1;
  localparam int ST_TXFREE = 2;
  localparam int ST_RXFULL = 3;
  localparam int ST_PERR   = 4;
  localparam int ST_FERR   = 5;
  localparam int ST_ADDR   = 6;
  // reset values
  localparam logic [15:0] DIV_RESET  = 16'h0000;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  // prescale ratios: base clock fosc/4 or fosc/16, measurement eight times slower
  localparam logic [6:0] PRE_FAST = 7'h03;
  localparam logic [6:0] PRE_SLOW = 7'h0f;
  localparam int ABD_RATIO = 8;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] OVERSAMPLE_MID  = 4'h7;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // character formats
  typedef enum logic [2:0] {
    AUF_MODE_7BIT = 3'b000,
    AUF_MODE_8BIT = 3'b001,
    AUF_MODE_EVEN = 3'b010,
    AUF_MODE_ODD  = 3'b011,
    AUF_MODE_ADDR = 3'b100,
    AUF_MODE_LIN  = 3'b101,
    AUF_MODE_DALI = 3'b110
  } auf_mode_t;
endpackage

// ==== rtl/auf_shifter.sv ====
// serial frame engine: one instance per direction, counts oversampled ticks
module auf_shifter (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        tick,
  input  wire logic        is_tx,
  input  wire logic        start,
  input  wire logic [3:0]  nbits,
  input  wire logic [8:0]  load_data,
  input  wire logic        line_in,
  output logic             busy,
  output logic             line_out,
  output logic [9:0]       frame_q,
  output logic             done
);
  logic [3:0]  phase_q;
  logic [3:0]  bitn_q;
  logic [10:0] sh_q;
  logic        busy_q;
  logic        out_q;
  logic        done_q;
  // tx samples at end of a bit, rx samples mid-bit
  wire logic [3:0] samp_at = is_tx ? auf_pkg::OVERSAMPLE_LAST : auf_pkg::OVERSAMPLE_MID;
  wire logic       at_samp = tick && (phase_q == samp_at);
  wire logic       last    = bitn_q == nbits;

  assign busy     = busy_q;
  assign line_out = out_q;
  assign done     = done_q;
  assign frame_q  = sh_q[10:1];

  // frame sequencer: start, data lsb first, optional ninth, stop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_q  <= 1'b0;
      out_q   <= 1'b1;
      done_q  <= 1'b0;
      phase_q <= 4'h0;
      bitn_q  <= 4'h0;
      sh_q    <= 11'h7ff;
    end
    else if (ce)
    begin
      done_q <= 1'b0;
      if (!busy_q && start)
      begin
        busy_q  <= 1'b1;
        phase_q <= 4'h0;
        bitn_q  <= 4'h0;
        sh_q    <= {1'b1, load_data, 1'b0};
        out_q   <= is_tx ? 1'b0 : 1'b1;
      end
      else if (busy_q && tick)
      begin
        phase_q <= phase_q + 4'h1;
        if (at_samp)
        begin
          bitn_q <= bitn_q + 4'h1;
          if (is_tx)
          begin
            sh_q  <= {1'b1, sh_q[10:1]};
            out_q <= last ? 1'b1 : sh_q[1];
          end
          else
            sh_q <= {line_in, sh_q[10:1]};
          if (last)
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ==== verification/auf_peer.sv ====
// remote serial peer: drives the receive line and captures frames from the transmit line
module auf_peer (
  input  wire logic aclk,
  input  wire logic tx_line,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // the line rests at mark between frames, as a pulled-up line would
  initial rx_line = 1'b1;

  // one frame: start, n bits of d lsb first, then a stop of the given level
  task automatic send(input logic [8:0] d, input int n, input logic stop_v, input int t);
    @(posedge aclk);
    rx_line <= 1'b0;
    repeat (t) @(posedge aclk);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= d[i];
      repeat (t) @(posedge aclk);
    end
    rx_line <= stop_v;
    repeat (t) @(posedge aclk);
    rx_line <= 1'b1;
  endtask

  // capture n bits at mid-bit; unused upper bits stay one so short frames compare cleanly
  task automatic recv(input int n, input int t, output logic [11:0] fr);
    int w;
    fr = '1;
    w = 0;
    while (tx_line !== 1'b0 && w < 5000)
    begin
      @(posedge aclk);
      w++;
    end
    repeat (t / 2) @(posedge aclk);
    for (int i = 0; i < n; i++)
    begin
      fr[i] = tx_line;
      repeat (t) @(posedge aclk);
    end
  endtask
endmodule

// ==== verification/auf_uart_tb.sv ====
// self-checking bench for the uart core: registers, framing, errors and rate measurement
module auf_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TB = 64;                           // clocks per bit, divisor 0, fast prescale
  localparam int TA = 256;                          // peer bit time while measuring
  localparam int ABD_EXP = 8 * TA / (4 * auf_pkg::ABD_RATIO);
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx_line, tx_line;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          failures, n_tests;

  auf_uart i_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_line(rx_line), .tx_line(tx_line)
  );

  auf_peer i_peer (.aclk(aclk), .tx_line(tx_line), .rx_line(rx_line));

  // free-running system clock
  always #2 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready && awvalid)
        awvalid <= 1'b0;
      if (wready && wvalid)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready && arvalid)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, auf_pkg::RESP_OKAY}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string s);
    logic [31:0] v;
    logic [1:0]  r;
    axr(a, v, r);
    chk({30'h0, r}, {30'h0, auf_pkg::RESP_OKAY}, s);
    chk(v & m, e, s);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: the sequence needs roughly 27000 cycles
  initial
  begin
    repeat (80000) @(posedge aclk);
    failures++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    logic [31:0] v;
    logic [1:0]  r;
    logic [8:0]  dd;
    logic [11:0] fr;
    logic [11:0] ex;
    logic [2:0]  am [3];
    int          nd;
    int          np;
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    am = '{3'h0, 3'h2, 3'h6};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and unmapped places
    rd(auf_pkg::OFS_CTRL, 32'h7ff, 32'h0, "ctrl reset");
    rd(auf_pkg::OFS_DIV, 32'hffff, 32'h0, "divisor reset");
    rd(auf_pkg::OFS_STATUS, 32'h7, 32'h6, "status reset");
    axr(8'h14, v, r);
    chk({30'h0, r}, {30'h0, auf_pkg::RESP_SLVERR}, "unmapped read");
    axw(8'h18, 32'h0, r);
    chk({30'h0, r}, {30'h0, auf_pkg::RESP_SLVERR}, "unmapped write");
    chk({31'h0, tx_line}, 32'h1, "tx idle");
    $display("test reset done");
    // the five formats 7-bit to address out and back; parity slot left clear so hardware must fill it
    for (int m = 0; m < 5; m++)
    begin
      nd = (m == 0) ? 7 : 8;
      np = (m >= 2) ? 1 : 0;
      dd = {1'b0, 8'hb6 ^ 8'(m)};
      if (nd == 7)
        dd[7] = 1'b0;
      if (m == 2)
        dd[8] = ^dd[7:0];
      if (m == 3)
        dd[8] = ~^dd[7:0];
      if (m == 4)
        dd[8] = 1'b1;
      ex = '1;
      ex[0] = 1'b0;
      for (int i = 0; i < nd + np; i++)
        ex[i + 1] = dd[i];
      wr(auf_pkg::OFS_CTRL, 32'h0b0 | 32'(m));
      fork
        i_peer.recv(nd + np + 2, TB, fr);
        wr(auf_pkg::OFS_TXHOLD, {23'h0, dd[8] & (m == 4), dd[7:0]});
      join
      chk({20'h0, fr}, {20'h0, ex}, "tx frame");
      i_peer.send(dd, nd + np, 1'b1, TB);
      repeat (4) @(posedge aclk);
      rd(auf_pkg::OFS_STATUS, 32'h78, 32'h08 | (m == 4 ? 32'h40 : 32'h0), "rx status");
      rd(auf_pkg::OFS_RXDATA, nd == 7 ? 32'h7f : 32'hff, {24'h0, dd[7:0]}, "rx data");
      rd(auf_pkg::OFS_STATUS, 32'h08, 32'h0, "rx full cleared");
      $display("test format %0d done", m);
    end
    // wrong parity, then a stop bit at space
    wr(auf_pkg::OFS_CTRL, 32'h0b3);
    i_peer.send(9'h05a, 9, 1'b1, TB);
    rd(auf_pkg::OFS_STATUS, 32'h10, 32'h10, "parity error");
    rd(auf_pkg::OFS_RXDATA, 32'h0, 32'h0, "drain");
    wr(auf_pkg::OFS_CTRL, 32'h0b1);
    i_peer.send(9'h0a5, 8, 1'b0, TB);
    rd(auf_pkg::OFS_STATUS, 32'h20, 32'h20, "frame error");
    rd(auf_pkg::OFS_RXDATA, 32'h0, 32'h0, "drain");
    $display("test errors done");
    // inversion acts at once, even with the transmitter off
    wr(auf_pkg::OFS_CTRL, 32'h200);
    repeat (2) @(posedge aclk);
    chk({31'h0, tx_line}, 32'h0, "inverted idle");
    wr(auf_pkg::OFS_CTRL, 32'h0);
    repeat (2) @(posedge aclk);
    chk({31'h0, tx_line}, 32'h1, "normal idle");
    $display("test inversion done");
    // rate measurement on a sync character
    wr(auf_pkg::OFS_DIV, 32'h3);
    wr(auf_pkg::OFS_CTRL, 32'h0e1);
    fork
      i_peer.send(9'h055, 8, 1'b1, TA);
      begin
        repeat (4 * TA) @(posedge aclk);
        rd(auf_pkg::OFS_DIV, 32'hffff, 32'h3, "divisor held");
        rd(auf_pkg::OFS_STATUS, 32'h3, 32'h0, "quiet low");
      end
    join
    repeat (4) @(posedge aclk);
    rd(auf_pkg::OFS_CTRL, 32'h40, 32'h0, "arm cleared");
    rd(auf_pkg::OFS_STATUS, 32'hb, 32'h3, "done quiet idle");
    axr(auf_pkg::OFS_DIV, v, r);
    chk({31'h0, v >= 32'(ABD_EXP - 1) && v <= 32'(ABD_EXP + 1)}, 32'h1, "measured");
    wr(auf_pkg::OFS_STATUS, 32'h1);
    rd(auf_pkg::OFS_STATUS, 32'h1, 32'h0, "done cleared");
    // lin times each sync unarmed; wake with arm skips one break first
    for (int k = 0; k < 2; k++)
    begin
      wr(auf_pkg::OFS_DIV, 32'h3);
      wr(auf_pkg::OFS_CTRL, k == 0 ? 32'h0a5 : 32'h1e1);
      if (k == 1)
        i_peer.send(9'h000, 8, 1'b0, TA);
      i_peer.send(9'h055, 8, 1'b1, TA);
      repeat (4) @(posedge aclk);
      rd(auf_pkg::OFS_STATUS, 32'h1, 32'h1, "sync timed");
      axr(auf_pkg::OFS_DIV, v, r);
      chk({31'h0, v >= 32'(ABD_EXP - 1) && v <= 32'(ABD_EXP + 1)}, 32'h1, "sync count");
      wr(auf_pkg::OFS_STATUS, 32'h1);
    end
    $display("test measurement done");
    // arm ignored in the 7-bit, even parity and dali formats
    wr(auf_pkg::OFS_DIV, 32'h5);
    for (int k = 0; k < 3; k++)
    begin
      wr(auf_pkg::OFS_CTRL, 32'h0e0 | 32'(am[k]));
      i_peer.send(9'h055, 8, 1'b1, TA);
      repeat (4) @(posedge aclk);
      rd(auf_pkg::OFS_STATUS, 32'h1, 32'h0, "arm ignored");
      rd(auf_pkg::OFS_DIV, 32'hffff, 32'h5, "divisor kept");
    end
    $display("test arm ignored done");
    print_verdict();
  end
endmodule
